// *** inc/gptc_pkg.sv ***
// Shared constants of the timer control block
package gptc_pkg;

	// Register byte offsets on the APB
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_CFG = 8'h04;
	localparam logic [7:0] OFS_A_PERIOD = 8'h08;
	localparam logic [7:0] OFS_A_MATCH = 8'h0c;
	localparam logic [7:0] OFS_B_COUNT = 8'h10;
	localparam logic [7:0] OFS_B_CAPTURE = 8'h14;
	localparam logic [7:0] OFS_STATUS = 8'h18;

	// Control register field positions
	localparam int CTRL_A_RUN_BIT = 0;
	localparam int CTRL_A_TRIG_BIT = 5;
	localparam int CTRL_A_INVERT_BIT = 6;
	localparam int CTRL_RESERVED_BIT = 7;
	localparam int CTRL_B_RUN_BIT = 8;
	localparam int CTRL_B_STALL_BIT = 9;
	localparam int CTRL_B_EDGE_LSB = 10;
	localparam int CTRL_B_EDGE_MSB = 11;

	// Configuration register field positions
	localparam int CFG_B_CAPTURE_BIT = 0;

	// Status register field positions
	localparam int STAT_B_RUNNING_BIT = 0;
	localparam int STAT_B_STALLED_BIT = 1;
	localparam int STAT_B_CAPTURED_BIT = 2;

	// Values after reset
	localparam logic [1:0] EDGE_RESET = 2'h0;
	localparam logic [15:0] A_PERIOD_RESET = 16'hffff;
	localparam logic [15:0] A_MATCH_RESET = 16'h0000;

	// Capture edge select codes
	localparam logic [1:0] EDGE_RISING = 2'h0;
	localparam logic [1:0] EDGE_FALLING = 2'h1;
	localparam logic [1:0] EDGE_RESERVED = 2'h2;
	localparam logic [1:0] EDGE_BOTH = 2'h3;

	// Counter widths
	localparam int COUNT_W = 16;

endpackage

// *** design/gptc_edge_detect.sv ***
`timescale 1ns/100ps
// Synchronises the capture pin and flags the selected edge
module gptc_edge_detect (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Pin and selection
	input wire logic pin_in,
	input wire logic [1:0] edge_sel,
	// Result
	output logic edge_hit
);

	logic sync1_q;
	logic sync2_q;
	logic last_q;
	logic rise;
	logic fall;

	// Two flops before any logic sees the pin
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			last_q <= 1'b0;
		end else begin
			sync1_q <= pin_in;
			sync2_q <= sync1_q;
			last_q <= sync2_q;
		end
	end

	// Edge decode; the reserved code never fires
	assign rise = sync2_q & ~last_q;
	assign fall = ~sync2_q & last_q;
	assign edge_hit = (edge_sel == gptc_pkg::EDGE_RISING) ? rise : // (RULE5)
		(edge_sel == gptc_pkg::EDGE_FALLING) ? fall :
		(edge_sel == gptc_pkg::EDGE_BOTH) ? (rise | fall) : 1'b0;

endmodule // gptc_edge_detect

// *** design/gptc_pwm.sv ***
`timescale 1ns/100ps
// Free-running wave generator for the first timer half
module gptc_pwm #(
	parameter int W = 16
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Control
	input wire logic run,
	input wire logic [W-1:0] period,
	input wire logic [W-1:0] match,
	// Raw wave, before any inversion
	output logic wave
);

	logic [W-1:0] count_q;
	logic [W-1:0] count_d;
	logic wrap;

	// Wrap at the period so a shrunken period takes effect at once
	assign wrap = (count_q >= period);
	assign count_d = wrap ? '0 : count_q + 1'b1;
	assign wave = run & (count_q < match);

	// Counter holds while halted so restart resumes the cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_q <= '0;
		end else if (run) begin
			count_q <= count_d;
		end
	end

endmodule // gptc_pwm

// *** design/gptc_top.sv ***
`timescale 1ns/100ps
// Functional notes
// (RULE1) Bit 9: stall enable, R/W, resets zero
// (RULE2) Bit 8: run enable, starts count or capture
// (RULE3) Bit 7: reserved, always reads zero
// (RULE4) Bit 6: invert wave output, resets zero
// (RULE5) Bits 11:10 select capture edge, reset zero
module gptc_top #(
	parameter int COUNT_W = gptc_pkg::COUNT_W
) (
	// APB slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Debug halt request from the processor, same clock
	input wire logic debug_halt,
	// Capture pin, asynchronous
	input wire logic capture_pin,
	// Timer outputs
	output logic wave_out,
	output logic second_half_running
);

	// Control and configuration state
	logic first_half_run_q;
	logic first_half_output_trigger_enable_q;
	logic first_half_wave_output_invert_q;
	logic second_half_run_enable_q;
	logic second_half_stall_enable_q;
	logic [1:0] second_half_capture_edge_select_q;
	logic capture_mode_q;
	logic [COUNT_W-1:0] a_period_q;
	logic [COUNT_W-1:0] a_match_q;

	// Timer B datapath state
	logic [COUNT_W-1:0] b_count_q;
	logic [COUNT_W-1:0] b_capture_q;
	logic b_captured_q;

	// Bus outputs
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	logic wave_out_q;
	logic running_q;

	// Decode wires
	logic [7:0] addr;
	logic setup;
	logic wr_done;
	logic rd_done;
	logic hit_ctrl;
	logic hit_cfg;
	logic hit_period;
	logic hit_match;
	logic hit_count;
	logic hit_capture;
	logic hit_status;
	logic mapped;
	logic [31:0] ctrl_word;
	logic [31:0] cfg_word;
	logic [31:0] status_word;
	logic [31:0] rd_mux;

	// Timer B control wires
	logic b_stalled;
	logic b_active;
	logic b_edge;
	logic b_capture_event;
	logic wave_raw;

	// Address decode on the low byte; upper address bits must be zero
	// Aliases above the low byte answer with an error, not a mirror
	assign addr = paddr[7:0];
	assign hit_ctrl = (paddr[31:8] == 24'h000000) && (addr == gptc_pkg::OFS_CTRL);
	assign hit_cfg = (paddr[31:8] == 24'h000000) && (addr == gptc_pkg::OFS_CFG);
	assign hit_period = (paddr[31:8] == 24'h000000) && (addr == gptc_pkg::OFS_A_PERIOD);
	assign hit_match = (paddr[31:8] == 24'h000000) && (addr == gptc_pkg::OFS_A_MATCH);
	assign hit_count = (paddr[31:8] == 24'h000000) && (addr == gptc_pkg::OFS_B_COUNT);
	assign hit_capture = (paddr[31:8] == 24'h000000) && (addr == gptc_pkg::OFS_B_CAPTURE);
	assign hit_status = (paddr[31:8] == 24'h000000) && (addr == gptc_pkg::OFS_STATUS);
	assign mapped = hit_ctrl | hit_cfg | hit_period | hit_match | hit_count | hit_capture | hit_status;

	// A write lands only at the completing edge, never in setup
	// Errored transfers leave every register untouched
	// Phase qualifiers; no wait state, answer ready in the first access cycle
	assign setup = psel & ~penable;
	assign wr_done = psel & penable & pready_q & pwrite & ~pslverr_q;
	assign rd_done = psel & penable & pready_q & ~pwrite;

	// Control word as software sees it
	always_comb begin
		ctrl_word = 32'h00000000;
		ctrl_word[gptc_pkg::CTRL_A_RUN_BIT] = first_half_run_q;
		ctrl_word[gptc_pkg::CTRL_A_TRIG_BIT] = first_half_output_trigger_enable_q;
		ctrl_word[gptc_pkg::CTRL_A_INVERT_BIT] = first_half_wave_output_invert_q; // (RULE4)
		ctrl_word[gptc_pkg::CTRL_RESERVED_BIT] = 1'b0; // (RULE3)
		ctrl_word[gptc_pkg::CTRL_B_RUN_BIT] = second_half_run_enable_q; // (RULE2)
		ctrl_word[gptc_pkg::CTRL_B_STALL_BIT] = second_half_stall_enable_q; // (RULE1)
		ctrl_word[gptc_pkg::CTRL_B_EDGE_MSB:gptc_pkg::CTRL_B_EDGE_LSB] = second_half_capture_edge_select_q; // (RULE5)
	end

	// Configuration and status words
	always_comb begin
		cfg_word = 32'h00000000;
		cfg_word[gptc_pkg::CFG_B_CAPTURE_BIT] = capture_mode_q;
		status_word = 32'h00000000;
		status_word[gptc_pkg::STAT_B_RUNNING_BIT] = running_q;
		status_word[gptc_pkg::STAT_B_STALLED_BIT] = b_stalled;
		status_word[gptc_pkg::STAT_B_CAPTURED_BIT] = b_captured_q;
	end

	// Read selection; unmapped reads return zero with an error
	// Count and capture words are zero-extended to the bus width
	assign rd_mux = hit_ctrl ? ctrl_word :
		hit_cfg ? cfg_word :
		hit_period ? {{(32-COUNT_W){1'b0}}, a_period_q} :
		hit_match ? {{(32-COUNT_W){1'b0}}, a_match_q} :
		hit_count ? {{(32-COUNT_W){1'b0}}, b_count_q} :
		hit_capture ? {{(32-COUNT_W){1'b0}}, b_capture_q} :
		hit_status ? status_word : 32'h00000000;

	// Bus answer registers, loaded in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h00000000;
		end else begin
			pready_q <= setup;
			pslverr_q <= setup & ~mapped;
			if (setup && !pwrite) begin
				prdata_q <= rd_mux;
			end
		end
	end

	// Control register; reserved bit has no storage at all
	// Trigger enable is stored only; nothing downstream reads it yet
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			first_half_run_q <= 1'b0;
			first_half_output_trigger_enable_q <= 1'b0;
			first_half_wave_output_invert_q <= 1'b0; // (RULE4)
			second_half_run_enable_q <= 1'b0; // (RULE2)
			second_half_stall_enable_q <= 1'b0; // (RULE1)
			second_half_capture_edge_select_q <= gptc_pkg::EDGE_RESET; // (RULE5)
		end else if (wr_done && hit_ctrl) begin
			first_half_run_q <= pwdata[gptc_pkg::CTRL_A_RUN_BIT];
			first_half_output_trigger_enable_q <= pwdata[gptc_pkg::CTRL_A_TRIG_BIT];
			first_half_wave_output_invert_q <= pwdata[gptc_pkg::CTRL_A_INVERT_BIT]; // (RULE4)
			second_half_run_enable_q <= pwdata[gptc_pkg::CTRL_B_RUN_BIT]; // (RULE2)
			second_half_stall_enable_q <= pwdata[gptc_pkg::CTRL_B_STALL_BIT]; // (RULE1)
			second_half_capture_edge_select_q <=
				pwdata[gptc_pkg::CTRL_B_EDGE_MSB:gptc_pkg::CTRL_B_EDGE_LSB]; // (RULE5)
		end
	end

	// Configuration and wave registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			capture_mode_q <= 1'b0;
			a_period_q <= gptc_pkg::A_PERIOD_RESET;
			a_match_q <= gptc_pkg::A_MATCH_RESET;
		end else begin
			if (wr_done && hit_cfg) begin
				capture_mode_q <= pwdata[gptc_pkg::CFG_B_CAPTURE_BIT];
			end
			if (wr_done && hit_period) begin
				a_period_q <= pwdata[COUNT_W-1:0];
			end
			if (wr_done && hit_match) begin
				a_match_q <= pwdata[COUNT_W-1:0];
			end
		end
	end

	// Stall only when both software allows it and debug asks for it
	// Stall freezes counting but not register access, so a debugger can look
	assign b_stalled = second_half_stall_enable_q & debug_halt; // (RULE1)
	assign b_active = second_half_run_enable_q & ~b_stalled; // (RULE2)
	assign b_capture_event = b_active & capture_mode_q & b_edge; // (RULE2)

	// Capture pin edge detector
	gptc_edge_detect u_edge (
		.pclk(pclk),
		.presetn(presetn),
		.pin_in(capture_pin),
		.edge_sel(second_half_capture_edge_select_q),
		.edge_hit(b_edge)
	);

	// Timer B counts in both modes; capture mode snapshots on edges
	// Count wraps silently at the top of its width
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			b_count_q <= '0;
			b_capture_q <= '0;
		end else begin
			if (b_active) begin
				b_count_q <= b_count_q + 1'b1; // (RULE2)
			end
			if (b_capture_event) begin
				b_capture_q <= b_count_q;
			end
		end
	end

	// Captured flag: a new capture wins over a clearing read
	// Set wins so a capture in the clearing cycle stays visible
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			b_captured_q <= 1'b0;
		end else if (b_capture_event) begin
			b_captured_q <= 1'b1;
		end else if (rd_done && hit_capture) begin
			b_captured_q <= 1'b0;
		end
	end

	// Timer A wave generator
	// A shorter period written at or below the current count wraps on the next clock
	gptc_pwm #(
		.W(COUNT_W)
	) u_pwm (
		.pclk(pclk),
		.presetn(presetn),
		.run(first_half_run_q),
		.period(a_period_q),
		.match(a_match_q),
		.wave(wave_raw)
	);

	// Registered outputs; inversion applied last so it covers idle level too
	// One cycle of latency keeps both pins free of decode glitches
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wave_out_q <= 1'b0;
			running_q <= 1'b0;
		end else begin
			wave_out_q <= wave_raw ^ first_half_wave_output_invert_q; // (RULE4)
			running_q <= b_active;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign wave_out = wave_out_q;
	assign second_half_running = running_q;

endmodule // gptc_top

// *** tb/gptc_sva.sv ***
`timescale 1ns/100ps
// Watches the control bits at the block's ports
module gptc_sva #(
	parameter int COUNT_W = 16
) (
	// APB side
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Timer side
	input wire logic debug_halt,
	input wire logic capture_pin,
	input wire logic wave_out,
	input wire logic second_half_running
);
	logic [11:0] sh_q;
	wire ctl_sel = psel && penable && pready && paddr == {24'h0, gptc_pkg::OFS_CTRL};

	// Shadow of the control word, taken only at completed writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) sh_q <= '0;
		else if (ctl_sel && pwrite) sh_q <= pwdata[11:0];
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_rsv; ctl_sel && !pwrite |-> prdata[7] == 1'b0; endproperty
	a_rsv: assert property (p_rsv)
		else $error("reserved control bit read as one");
	property p_rdback; ctl_sel && !pwrite |-> prdata[11:8] == sh_q[11:8] && prdata[6] == sh_q[6]; endproperty
	a_rdback: assert property (p_rdback)
		else $error("control field read back differs from last write");
	// Three cycles allowed though run and stall pass only the one output register
	property p_run_on; (sh_q[8] && !debug_halt)[*3] |-> second_half_running; endproperty
	a_run_on: assert property (p_run_on)
		else $error("second half not running while enabled");
	property p_run_off; (!sh_q[8])[*2] |-> !second_half_running; endproperty
	a_run_off: assert property (p_run_off)
		else $error("second half running while disabled");
	property p_stall; (sh_q[9] && debug_halt)[*3] |-> !second_half_running; endproperty
	a_stall: assert property (p_stall)
		else $error("second half not stalled on halt");
	property p_wave; (!sh_q[0] && $stable(sh_q))[*3] |-> wave_out == sh_q[6]; endproperty
	a_wave: assert property (p_wave)
		else $error("idle wave output ignores invert bit");

	c_stall: cover property (sh_q[9] && sh_q[8] && debug_halt);
	c_inv: cover property (sh_q[6] && wave_out);
	c_both: cover property (sh_q[11:10] == 2'h3 && sh_q[8]);
endmodule // gptc_sva

bind gptc_top gptc_sva #(.COUNT_W(COUNT_W)) u_gptc_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .debug_halt(debug_halt), .capture_pin(capture_pin), .wave_out(wave_out),
	.second_half_running(second_half_running));

// *** tb/test_timer_control_bits.sv ***
`timescale 1ns/100ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
	$display("[FAIL] %s expected %h seen %h", n, e, g); end end
module test_timer_control_bits;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, debug_halt = 1'b0, capture_pin = 1'b0;
	logic [31:0] paddr = '0, pwdata = '0, prdata, rdat;
	logic pready, pslverr, wave_out, second_half_running, rerr;
	int n_errors = 0;
	int samples_checked = 0;
	localparam logic [31:0] CTRL = {24'h0, gptc_pkg::OFS_CTRL};
	localparam logic [31:0] CFG = {24'h0, gptc_pkg::OFS_CFG};
	localparam logic [31:0] CAP = {24'h0, gptc_pkg::OFS_B_CAPTURE};
	localparam logic [31:0] STAT = {24'h0, gptc_pkg::OFS_STATUS};
	localparam logic [31:0] CNT = {24'h0, gptc_pkg::OFS_B_COUNT};
	localparam logic [31:0] MATCH = {24'h0, gptc_pkg::OFS_A_MATCH};
	logic [31:0] cnt0;

	gptc_top u_gptc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.debug_halt(debug_halt), .capture_pin(capture_pin), .wave_out(wave_out),
		.second_half_running(second_half_running));

	// 50 MHz clock
	initial begin
		forever #10 pclk = ~pclk;
	end

	task report_and_stop;
		$display("errors %0d checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	// One APB transfer; the slave's latency is never assumed
	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (i == 20) begin
			n_errors++;
			report_and_stop();
		end
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d); apb(1'b1, a, d); endtask
	task automatic rd(input logic [31:0] a); apb(1'b0, a, '0); endtask

	task t_reset;
		rd(CTRL);
		`CHK("ctrl after reset", 32'h0, rdat)
		`CHK("running after reset", 1'b0, second_half_running)
	endtask

	// All ones but bit 0 written; reserved bit must still read zero
	task t_fields;
		wr(CTRL, 32'hfffffffe);
		rd(CTRL);
		`CHK("ctrl fields", 32'h00000f60, rdat)
		repeat (3) @(posedge pclk);
		`CHK("inverted idle wave", 1'b1, wave_out)
		`CHK("running, no halt", 1'b1, second_half_running)
		// Back-to-back read setups lie three cycles apart
		rd(CNT);
		cnt0 = rdat;
		rd(CNT);
		`CHK("count advances", cnt0 + 32'h3, rdat)
		debug_halt <= 1'b1;
		repeat (4) @(posedge pclk);
		`CHK("stalled on halt", 1'b0, second_half_running)
		rd(CNT);
		cnt0 = rdat;
		rd(CNT);
		`CHK("count frozen", cnt0, rdat)
		wr(CTRL, 32'h00000100);
		repeat (4) @(posedge pclk);
		`CHK("halt ignored", 1'b1, second_half_running)
		wr(CTRL, 32'h0);
		debug_halt <= 1'b0;
		repeat (4) @(posedge pclk);
		`CHK("disabled", 1'b0, second_half_running)
		`CHK("plain idle wave", 1'b0, wave_out)
		// Match at the top keeps the running wave high for a long stretch
		wr(MATCH, 32'h0000ffff);
		wr(CTRL, 32'h00000001);
		repeat (3) @(posedge pclk);
		`CHK("running wave", 1'b1, wave_out)
		wr(CTRL, 32'h00000041);
		repeat (3) @(posedge pclk);
		`CHK("inverted running wave", 1'b0, wave_out)
		wr(CTRL, 32'h0);
	endtask

	// Every edge code, each tried with a rise and a fall
	task automatic t_edges;
		logic [1:0] code;
		for (int k = 0; k < 4; k++) begin
			code = k[1:0];
			wr(CFG, 32'h1);
			// Read-modify-write keeps the reserved bit as read
			rd(CTRL);
			wr(CTRL, (rdat & 32'hfffff0ff) | {20'h0, code, 2'h1, 8'h0});
			rd(CTRL);
			`CHK("edge field", ({code, 2'h1}), rdat[11:8])
			rd(CAP);
			capture_pin <= 1'b1;
			repeat (6) @(posedge pclk);
			rd(STAT);
			`CHK("rise capture", code == 2'h0 || code == 2'h3, rdat[2])
			rd(CAP);
			capture_pin <= 1'b0;
			repeat (6) @(posedge pclk);
			rd(STAT);
			`CHK("fall capture", code == 2'h1 || code == 2'h3, rdat[2])
		end
		wr(CTRL, 32'h0);
		wr(CFG, 32'h0);
	endtask

	task t_unmapped;
		rd(32'h00000100);
		`CHK("unmapped error", 1'b1, rerr)
		`CHK("unmapped data", 32'h0, rdat)
	endtask

	// Reset for 8 cycles, then the scenarios
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_fields();
		t_edges();
		t_unmapped();
		report_and_stop();
	end
endmodule // test_timer_control_bits
